// file: logic/lpm_ctrl.sv
/*
 * lpm_ctrl: low-power mode controller with axi4-lite registers.
 * assumes: inputs synchronous to aclk; wake sources are pulses or levels.
 */
`timescale 1ns/1ps
module lpm_ctrl #(
    parameter int IO_COUNT = 16
) (
    input  wire logic             aclk,
    input  wire logic             aresetn,
    // axi4-lite slave
    input  wire logic [7:0]       s_axi_awaddr,
    input  wire logic             s_axi_awvalid,
    output logic                  s_axi_awready,
    input  wire logic [31:0]      s_axi_wdata,
    input  wire logic [3:0]       s_axi_wstrb,
    input  wire logic             s_axi_wvalid,
    output logic                  s_axi_wready,
    output logic [1:0]            s_axi_bresp,
    output logic                  s_axi_bvalid,
    input  wire logic             s_axi_bready,
    input  wire logic [7:0]       s_axi_araddr,
    input  wire logic             s_axi_arvalid,
    output logic                  s_axi_arready,
    output logic [31:0]           s_axi_rdata,
    output logic [1:0]            s_axi_rresp,
    output logic                  s_axi_rvalid,
    input  wire logic             s_axi_rready,
    // processor and radio side
    input  wire logic             wait_entry,
    input  wire logic             wake_event,
    input  wire logic [2:0]       radio_mode_req,
    input  wire logic             radio_in_use,
    input  wire logic             periph_hsi_req,
    // always-on wake sources and supply status
    input  wire logic             external_reset_pin,
    input  wire logic             independent_watchdog_reset,
    input  wire logic [1:0]       wakeup_pin_event,
    input  wire logic             rtc_event,
    input  wire logic             oscillator_failure_detector,
    input  wire logic             supply_stable,
    // power and clock controls
    output logic                  main_regulator_en,
    output logic                  low_power_regulator_en,
    output logic                  core_supply_domain_on,
    output logic                  brownout_monitor_en,
    output logic                  app_clk_en,
    output logic                  app_clk_cap_2mhz,
    output logic                  internal_16mhz_oscillator_en,
    output logic                  low_speed_osc_en,
    output logic                  rtc_en,
    output logic [1:0]            sysclk_sel,
    output logic                  memory_bank_one_ret,
    output logic                  memory_bank_two_a_ret,
    output logic                  memory_bank_two_b_ret,
    output logic                  regs_retained,
    output logic                  radio_wait_en,
    output logic [2*IO_COUNT-1:0] io_pull,
    output logic [2:0]            eff_mode
);
    typedef enum logic [1:0] {LPM_SQ_IDLE, LPM_SQ_SUPPLY, LPM_SQ_CLOCK} lpm_seq_t;

    logic [31:0]            ctrl_q;
    logic [1:0]             wkpol_q;
    logic [2*IO_COUNT-1:0]  iopull_q;
    logic [2:0]             cpu_mode_q;
    logic [2:0]             eff_q;
    logic [1:0]             wkprev_q;
    lpm_seq_t               seq_q;
    logic [7:0]             cnt_q;
    logic                   aw_hold_q, w_hold_q;
    logic [7:0]             awaddr_q;
    logic [31:0]            wdata_q;

    // write channel: accept address and data in either order
    wire aw_take  = s_axi_awvalid && s_axi_awready;
    wire w_take   = s_axi_wvalid && s_axi_wready;
    wire wr_fire  = (aw_hold_q || aw_take) && (w_hold_q || w_take) && !s_axi_bvalid;
    wire [7:0]  wr_addr = aw_hold_q ? awaddr_q : s_axi_awaddr;
    wire [31:0] wr_data = w_hold_q ? wdata_q : s_axi_wdata;
    wire wr_ctrl  = wr_fire && wr_addr == lpm_pkg::OFF_CTRL;
    wire wr_wkcfg = wr_fire && wr_addr == lpm_pkg::OFF_WAKECFG;
    wire wr_iop   = wr_fire && wr_addr == lpm_pkg::OFF_IOPULL;
    wire wr_ok    = wr_ctrl || wr_wkcfg || wr_iop;

    // byte-lane merge for ctrl
    wire [31:0] strb_mask = {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}}, {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}};
    wire [31:0] ctrl_d    = (ctrl_q & ~strb_mask) | (wr_data & strb_mask);
    wire [2:0]  sel_mode  = ctrl_q[lpm_pkg::CTRL_MODE_LSB +: 3];

    // wake detection with per-pin polarity
    wire [1:0] pin_rise = wakeup_pin_event & ~wkprev_q;
    wire [1:0] pin_fall = ~wakeup_pin_event & wkprev_q;
    wire [1:0] pin_edge = (wkpol_q & pin_fall) | (~wkpol_q & pin_rise);
    wire stby_wake = external_reset_pin || independent_watchdog_reset || (|pin_edge)
                     || rtc_event || oscillator_failure_detector;
    wire shut_wake = external_reset_pin || (|pin_edge) || rtc_event;
    wire in_stop   = eff_q == lpm_pkg::LPM_STOP0 || eff_q == lpm_pkg::LPM_STOP1;
    wire in_off    = eff_q == lpm_pkg::LPM_STBY || eff_q == lpm_pkg::LPM_SHUT;
    wire wake_now  = (eff_q == lpm_pkg::LPM_STBY) ? stby_wake :
                     (eff_q == lpm_pkg::LPM_SHUT) ? shut_wake : wake_event;

    // cpu requested mode: entry on wait, exit on wake; lp run entered and left by ctrl write
    logic [2:0] cpu_mode_d;
    always_comb begin
        cpu_mode_d = cpu_mode_q;
        if (cpu_mode_q != lpm_pkg::LPM_RUN && cpu_mode_q != lpm_pkg::LPM_LPRUN) begin
            if (wake_now) begin
                // lp sleep returns to lp run, everything else to run
                cpu_mode_d = (cpu_mode_q == lpm_pkg::LPM_LPSLP) ? lpm_pkg::LPM_LPRUN
                                                                : lpm_pkg::LPM_RUN;
            end
        end else if (wait_entry) begin
            if (sel_mode == lpm_pkg::LPM_LPSLP) begin
                // lp sleep refused unless already in lp run
                if (cpu_mode_q == lpm_pkg::LPM_LPRUN) cpu_mode_d = sel_mode;
            end else if (sel_mode != lpm_pkg::LPM_LPRUN) begin
                cpu_mode_d = sel_mode;
            end
        end else if (sel_mode == lpm_pkg::LPM_LPRUN && cpu_mode_q == lpm_pkg::LPM_RUN) begin
            cpu_mode_d = sel_mode; // lp run needs no wait instruction
        end else if (sel_mode == lpm_pkg::LPM_RUN && cpu_mode_q == lpm_pkg::LPM_LPRUN) begin
            cpu_mode_d = sel_mode;
        end
    end

    // higher of the two requests; lower code is more active
    wire [2:0] target = (cpu_mode_q < radio_mode_req) ? cpu_mode_q : radio_mode_req;

    // derived controls for the target mode
    wire t_main  = target == lpm_pkg::LPM_RUN || target == lpm_pkg::LPM_SLEEP
                   || target == lpm_pkg::LPM_STOP0;
    wire t_lp    = target == lpm_pkg::LPM_LPRUN || target == lpm_pkg::LPM_LPSLP
                   || target == lpm_pkg::LPM_STOP1
                   || (target == lpm_pkg::LPM_STBY && ctrl_q[lpm_pkg::CTRL_SRAM_RET]);
    wire t_core  = !(target == lpm_pkg::LPM_STBY || target == lpm_pkg::LPM_SHUT);
    wire t_clk   = target == lpm_pkg::LPM_RUN || target == lpm_pkg::LPM_LPRUN;
    wire t_ret   = t_core || (target == lpm_pkg::LPM_STBY && ctrl_q[lpm_pkg::CTRL_SRAM_RET]);
    wire chg     = target != eff_q;
    wire cnt_done = cnt_q == 8'(lpm_pkg::REG_SETTLE_CYC);

    // wake clock choice
    wire [1:0] stop_clk = (radio_in_use || !ctrl_q[lpm_pkg::CTRL_STOPCLK]) ? lpm_pkg::CLK_F16
                                                                          : lpm_pkg::CLK_MHI;
    wire [1:0] wake_clk = (eff_q == lpm_pkg::LPM_SHUT) ? lpm_pkg::CLK_M4 :
                          (eff_q == lpm_pkg::LPM_STBY) ? lpm_pkg::CLK_F16 :
                          in_stop ? stop_clk : sysclk_sel;

    // register file and bus
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl_q   <= lpm_pkg::CTRL_RESET;
            wkpol_q  <= 2'h0;
            iopull_q <= '0;
        end else begin
            if (wr_ctrl) ctrl_q <= ctrl_d;
            if (wr_wkcfg) wkpol_q <= wr_data[lpm_pkg::WK_POL1:lpm_pkg::WK_POL0];
            if (wr_iop) iopull_q <= wr_data[2*IO_COUNT-1:0];
        end
    end

    // write handshake
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_hold_q <= 1'b0;
            w_hold_q  <= 1'b0;
            awaddr_q  <= 8'h00;
            wdata_q   <= 32'h0000_0000;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= 2'h0;
        end else begin
            if (aw_take) begin
                aw_hold_q <= 1'b1;
                awaddr_q  <= s_axi_awaddr;
            end
            if (w_take) begin
                w_hold_q <= 1'b1;
                wdata_q  <= s_axi_wdata;
            end
            if (wr_fire) begin
                aw_hold_q <= 1'b0;
                w_hold_q  <= 1'b0;
                s_axi_bvalid <= 1'b1;
                s_axi_bresp  <= wr_ok ? 2'h0 : 2'h2;
            end else if (s_axi_bvalid && s_axi_bready) begin
                s_axi_bvalid <= 1'b0;
            end
        end
    end
    assign s_axi_awready = !aw_hold_q && !s_axi_bvalid;
    assign s_axi_wready  = !w_hold_q && !s_axi_bvalid;

    // read channel; one-cycle answer
    wire rd_take = s_axi_arvalid && s_axi_arready;
    wire [31:0] status_word = {22'h0, seq_q, cpu_mode_q, eff_q, 2'h0} | {30'h0, sysclk_sel};
    wire [31:0] rd_word =
        (s_axi_araddr == lpm_pkg::OFF_CTRL)    ? ctrl_q :
        (s_axi_araddr == lpm_pkg::OFF_WAKECFG) ? {30'h0, wkpol_q} :
        (s_axi_araddr == lpm_pkg::OFF_IOPULL)  ? 32'(iopull_q) :
        (s_axi_araddr == lpm_pkg::OFF_STATUS)  ? status_word : 32'h0;
    wire rd_ok = s_axi_araddr == lpm_pkg::OFF_CTRL || s_axi_araddr == lpm_pkg::OFF_WAKECFG
                 || s_axi_araddr == lpm_pkg::OFF_IOPULL || s_axi_araddr == lpm_pkg::OFF_STATUS;
    assign s_axi_arready = !s_axi_rvalid;
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_rvalid <= 1'b0;
            s_axi_rdata  <= 32'h0000_0000;
            s_axi_rresp  <= 2'h0;
        end else if (rd_take) begin
            s_axi_rvalid <= 1'b1;
            s_axi_rdata  <= rd_word;
            s_axi_rresp  <= rd_ok ? 2'h0 : 2'h2;
        end else if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end

    // mode requests and wake edge memory
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cpu_mode_q <= lpm_pkg::LPM_RUN;
            wkprev_q   <= 2'h0;
        end else begin
            cpu_mode_q <= cpu_mode_d;
            wkprev_q   <= wakeup_pin_event;
        end
    end

    // transition sequencer: clock off, supply change, wait settle, then clock on for run and lp run targets
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            seq_q <= LPM_SQ_IDLE;
            cnt_q <= 8'h00;
            eff_q <= lpm_pkg::LPM_RUN;
            app_clk_en <= 1'b1;
            main_regulator_en <= 1'b1;
            low_power_regulator_en <= 1'b0;
            core_supply_domain_on <= 1'b1;
            sysclk_sel <= lpm_pkg::CLK_M4;
        end else begin
            unique case (seq_q)
                LPM_SQ_IDLE: if (chg) begin
                    app_clk_en <= 1'b0;
                    seq_q <= LPM_SQ_SUPPLY;
                end
                LPM_SQ_SUPPLY: begin
                    main_regulator_en      <= t_main;
                    low_power_regulator_en <= t_lp;
                    core_supply_domain_on  <= t_core;
                    // exit clock only when leaving a stop or off mode
                    if (in_stop || in_off) begin
                        sysclk_sel <= wake_clk;
                    end
                    cnt_q <= 8'h00;
                    seq_q <= LPM_SQ_CLOCK;
                end
                LPM_SQ_CLOCK: begin
                    if (!cnt_done) cnt_q <= cnt_q + 8'h01;
                    if (cnt_done && supply_stable) begin
                        eff_q <= target;
                        app_clk_en <= t_clk;
                        seq_q <= LPM_SQ_IDLE;
                    end
                end
            endcase
        end
    end

    // per-mode static outputs
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            brownout_monitor_en <= 1'b1;
            app_clk_cap_2mhz <= 1'b0;
            internal_16mhz_oscillator_en <= 1'b1;
            low_speed_osc_en <= 1'b1;
            rtc_en <= 1'b1;
            memory_bank_one_ret <= 1'b1;
            memory_bank_two_a_ret <= 1'b1;
            memory_bank_two_b_ret <= 1'b1;
            regs_retained <= 1'b1;
            radio_wait_en <= 1'b1;
            io_pull <= '0;
        end else begin
            brownout_monitor_en <= eff_q != lpm_pkg::LPM_SHUT;
            app_clk_cap_2mhz <= eff_q == lpm_pkg::LPM_LPRUN || eff_q == lpm_pkg::LPM_LPSLP;
            // stop gates the fast oscillator unless a peripheral wants it
            internal_16mhz_oscillator_en <= in_stop ? periph_hsi_req : !in_off;
            low_speed_osc_en <= eff_q != lpm_pkg::LPM_SHUT || ctrl_q[lpm_pkg::CTRL_SLOW_KEEP];
            rtc_en <= !(in_stop || in_off) || ctrl_q[lpm_pkg::CTRL_RTC_KEEP];
            memory_bank_one_ret <= t_ret;
            memory_bank_two_a_ret <= t_ret;
            memory_bank_two_b_ret <= t_ret;
            regs_retained <= t_core;
            radio_wait_en <= in_stop || !(eff_q == lpm_pkg::LPM_LPRUN || eff_q == lpm_pkg::LPM_LPSLP);
            io_pull <= in_off ? iopull_q : '0;
        end
    end
    assign eff_mode = eff_q;
endmodule : lpm_ctrl

// file: logic/lpm_pkg.sv
/*
 * lpm_pkg: mode codes, clock codes and register map of the mode controller.
 * assumes: referenced as lpm_pkg::name.
 */
package lpm_pkg;
    // system power modes, ordered from most to least active
    typedef enum logic [2:0] {
        LPM_RUN    = 3'h0,
        LPM_SLEEP  = 3'h1,
        LPM_LPRUN  = 3'h2,
        LPM_LPSLP  = 3'h3,
        LPM_STOP0  = 3'h4,
        LPM_STOP1  = 3'h5,
        LPM_STBY   = 3'h6,
        LPM_SHUT   = 3'h7
    } lpm_mode_t;

    // system clock source after wake
    localparam logic [1:0] CLK_M4      = 2'h0;
    localparam logic [1:0] CLK_F16     = 2'h1;
    localparam logic [1:0] CLK_MHI     = 2'h2;

    // register byte offsets
    localparam logic [7:0] OFF_CTRL    = 8'h00;
    localparam logic [7:0] OFF_WAKECFG = 8'h04;
    localparam logic [7:0] OFF_IOPULL  = 8'h08;
    localparam logic [7:0] OFF_STATUS  = 8'h0c;

    // ctrl fields
    localparam int CTRL_MODE_LSB   = 0;
    localparam int CTRL_STOPCLK    = 4;
    localparam int CTRL_RTC_KEEP   = 5;
    localparam int CTRL_SRAM_RET   = 6;
    localparam int CTRL_SLOW_KEEP  = 7;
    // wakecfg fields
    localparam int WK_POL0         = 0;
    localparam int WK_POL1         = 1;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

    // settle time of a regulator change, ns
    localparam int REG_SETTLE_NS   = 100;
    localparam int CLK_PERIOD_NS   = 20;
    localparam int REG_SETTLE_CYC  = (REG_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
endpackage : lpm_pkg

// file: verif/lpm_ctrl_asserts.sv
/* lpm_ctrl_chk: concurrent checks on the mode controller ports.
   assumes: bound into lpm_ctrl; one clock, synchronous active-low reset. */
`timescale 1ns/1ps
module lpm_ctrl_chk #(
    parameter int IO_COUNT = 16
) (
    input wire logic       aclk,
    input wire logic       aresetn,
    input wire logic       s_axi_awvalid,
    input wire logic       s_axi_awready,
    input wire logic       s_axi_wvalid,
    input wire logic       s_axi_wready,
    input wire logic       s_axi_bvalid,
    input wire logic       s_axi_arvalid,
    input wire logic       s_axi_arready,
    input wire logic       s_axi_rvalid,
    input wire logic [2:0] radio_mode_req,
    input wire logic       supply_stable,
    input wire logic       main_regulator_en,
    input wire logic       low_power_regulator_en,
    input wire logic       core_supply_domain_on,
    input wire logic       brownout_monitor_en,
    input wire logic       app_clk_en,
    input wire logic       app_clk_cap_2mhz,
    input wire logic [1:0] sysclk_sel,
    input wire logic       memory_bank_one_ret,
    input wire logic       regs_retained,
    input wire logic       low_speed_osc_en,
    input wire logic       radio_wait_en,
    input wire logic [2:0] eff_mode
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // first cycle in mode m
    sequence s_arr(logic [2:0] m);
        $changed(eff_mode) && eff_mode == m;
    endsequence
    // first cycle after mode m
    sequence s_left(logic [2:0] m);
        $changed(eff_mode) && $past(eff_mode) == m;
    endsequence

    property p_rst; $rose(aresetn) |-> eff_mode == 3'h0 && app_clk_en && main_regulator_en; endproperty
    a_rst: assert property (p_rst) else $error("reset mode");
    property p_slp; s_arr(3'h1) |-> !app_clk_en && main_regulator_en && core_supply_domain_on; endproperty
    a_slp: assert property (p_slp) else $error("sleep outputs wrong");
    property p_lpr; s_arr(3'h2) |-> app_clk_en && low_power_regulator_en && !main_regulator_en ##1 app_clk_cap_2mhz;
    endproperty
    a_lpr: assert property (p_lpr) else $error("lprun outputs");
    property p_lps; s_arr(3'h3) |-> $past(eff_mode) == 3'h2 && !app_clk_en; endproperty
    a_lps: assert property (p_lps) else $error("lpsleep entry");
    property p_st0; s_arr(3'h4) |-> main_regulator_en && regs_retained && low_speed_osc_en && radio_wait_en; endproperty
    a_st0: assert property (p_st0) else $error("stop0 outputs wrong");
    property p_st1; s_arr(3'h5) |-> !main_regulator_en && low_power_regulator_en && memory_bank_one_ret; endproperty
    a_st1: assert property (p_st1) else $error("stop1 outputs wrong");
    property p_sby; s_arr(3'h6) |-> !core_supply_domain_on && brownout_monitor_en && !regs_retained; endproperty
    a_sby: assert property (p_sby) else $error("standby outputs wrong");
    property p_shd; s_arr(3'h7) |-> !memory_bank_one_ret && !regs_retained ##1 !brownout_monitor_en; endproperty
    a_shd: assert property (p_shd) else $error("shutdown outputs wrong");
    property p_wk6; s_left(3'h6) |-> sysclk_sel == lpm_pkg::CLK_F16; endproperty
    a_wk6: assert property (p_wk6) else $error("stby wake clk");
    property p_wk7; s_left(3'h7) |-> sysclk_sel == lpm_pkg::CLK_M4; endproperty
    a_wk7: assert property (p_wk7) else $error("shut wake clk");
    property p_clk; $rose(app_clk_en) |-> core_supply_domain_on && $past(supply_stable); endproperty
    a_clk: assert property (p_clk) else $error("core clock before supply");
    property p_rad; $changed(eff_mode) |-> eff_mode <= radio_mode_req; endproperty
    a_rad: assert property (p_rad) else $error("mode below radio need");
    property p_axw; s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready |=> s_axi_bvalid; endproperty
    a_axw: assert property (p_axw) else $error("write response late");
    property p_axr; s_axi_arvalid && s_axi_arready |=> s_axi_rvalid && !s_axi_arready; endproperty
    a_axr: assert property (p_axr) else $error("read response late");
endmodule : lpm_ctrl_chk

bind lpm_ctrl lpm_ctrl_chk #(.IO_COUNT(IO_COUNT)) lpm_ctrl_chk_inst (.*);

// file: verif/lpm_far_model.sv
/* lpm_far_model: regulator settle counter and combinational radio mode request beside the controller.
   assumes: same clock and reset as lpm_ctrl; the bench picks radio activity and speed. */
`timescale 1ns/1ps
module lpm_far_model (
    input  wire logic       aclk,
    input  wire logic       aresetn,
    input  wire logic       slow,
    input  wire logic       radio_on,
    input  wire logic [2:0] radio_lvl,
    input  wire logic       main_regulator_en,
    input  wire logic       low_power_regulator_en,
    input  wire logic       core_supply_domain_on,
    output logic            supply_stable,
    output logic [2:0]      radio_mode_req,
    output logic            radio_in_use
);
    logic [2:0] regs_q;
    logic [3:0] cnt_q;
    wire  [2:0] regs_now = {main_regulator_en, low_power_regulator_en, core_supply_domain_on};

    // regulator change restarts the settle count
    always_ff @(posedge aclk) begin
        regs_q <= regs_now;
        if (!aresetn) cnt_q <= '0;
        else if (regs_q != regs_now) cnt_q <= slow ? 4'hc : 4'h1;
        else if (cnt_q != 4'h0) cnt_q <= cnt_q - 4'h1;
    end
    assign supply_stable = (cnt_q == 4'h0) && (regs_q == regs_now);
    // radio switched off asks for nothing, so low modes stay reachable
    assign radio_mode_req = radio_on ? radio_lvl : 3'h7;
    assign radio_in_use = radio_on;
endmodule : lpm_far_model

// file: verif/test_low_power_mode_controller.sv
/* test_low_power_mode_controller: register-bus and mode sequencing tests.
   assumes: package, design, checker and model compiled first. */
`timescale 1ns/1ps
`define CHK(nm, e, g) begin n_checks++; if ((g) !== (e)) begin num_errors++; $display("FAIL %s exp %h got %h", nm, e, g); end end
module test_low_power_mode_controller;
    logic        aclk = 1'h0, aresetn = 1'h0;
    logic [7:0]  s_axi_awaddr = '0, s_axi_araddr = '0, io_pull;
    logic [31:0] s_axi_wdata = '0, s_axi_rdata, dat;
    logic [3:0]  s_axi_wstrb = 4'hf;
    logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic        wait_entry = 0, periph_hsi_req = 0, slow = 0, radio_on = 0;
    logic [5:0]  ev = '0;
    logic [2:0]  radio_lvl = '0, eff_mode, radio_mode_req;
    logic [1:0]  rsp, s_axi_bresp, s_axi_rresp, sysclk_sel;
    logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, supply_stable, radio_in_use;
    logic        main_regulator_en, low_power_regulator_en, core_supply_domain_on, brownout_monitor_en, app_clk_en;
    logic        app_clk_cap_2mhz, internal_16mhz_oscillator_en, low_speed_osc_en, rtc_en, regs_retained, radio_wait_en;
    logic        memory_bank_one_ret, memory_bank_two_a_ret, memory_bank_two_b_ret;
    int          num_errors = 0, n_checks = 0;

    always #10 aclk = ~aclk;
    // wake sources: 0 reset pin, 1 watchdog, 2 rtc, 3 osc failure, 4 wake pin, 5 event
    lpm_ctrl #(.IO_COUNT(4)) lpm_ctrl_inst (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
        .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .wait_entry, .wake_event(ev[5]), .radio_mode_req, .radio_in_use, .periph_hsi_req,
        .external_reset_pin(ev[0]), .independent_watchdog_reset(ev[1]), .wakeup_pin_event({ev[4], ev[4]}),
        .rtc_event(ev[2]), .oscillator_failure_detector(ev[3]), .supply_stable, .main_regulator_en,
        .low_power_regulator_en, .core_supply_domain_on, .brownout_monitor_en, .app_clk_en, .app_clk_cap_2mhz,
        .internal_16mhz_oscillator_en, .low_speed_osc_en, .rtc_en, .sysclk_sel, .memory_bank_one_ret,
        .memory_bank_two_a_ret, .memory_bank_two_b_ret, .regs_retained, .radio_wait_en, .io_pull, .eff_mode);
    lpm_far_model lpm_far_model_inst (.aclk, .aresetn, .slow, .radio_on, .radio_lvl, .main_regulator_en,
        .low_power_regulator_en, .core_supply_domain_on, .supply_stable, .radio_mode_req, .radio_in_use);

    task automatic finish_test();
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : finish_test

    // each half drops after its ready edge
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic ad, wd;
        ad = 0;
        wd = 0;
        @(posedge aclk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        s_axi_bready <= 1'h1;
        while (!(ad && wd)) begin
            @(negedge aclk);
            ad = ad | s_axi_awready;
            wd = wd | s_axi_wready;
            @(posedge aclk);
            s_axi_awvalid <= !ad;
            s_axi_wvalid <= !wd;
        end
        do @(negedge aclk); while (s_axi_bvalid !== 1'h1);
        r = s_axi_bresp;
        @(posedge aclk);
        s_axi_bready <= 1'h0;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [31:0] d);
        @(posedge aclk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        s_axi_rready <= 1'h1;
        do @(negedge aclk); while (s_axi_arready !== 1'h1);
        @(posedge aclk);
        s_axi_arvalid <= 1'h0;
        do @(negedge aclk); while (s_axi_rvalid !== 1'h1);
        d = s_axi_rdata;
        @(posedge aclk);
        s_axi_rready <= 1'h0;
    endtask : rd

    task automatic wait_mode(input logic [2:0] m);
        for (int n = 0; n < 300 && eff_mode !== m; n++) @(negedge aclk);
        @(negedge aclk);
        `CHK("eff_mode", m, eff_mode)
    endtask : wait_mode

    // mode is written before the wait pulse, never after
    task automatic go(input logic [31:0] c, input logic [2:0] m);
        wr(8'h00, c, rsp);
        @(posedge aclk);
        wait_entry <= 1'h1;
        @(posedge aclk);
        wait_entry <= 1'h0;
        wait_mode(m);
    endtask : go

    task automatic kick(input int i);
        @(posedge aclk);
        ev[i] <= 1'h1;
        @(posedge aclk);
        ev[i] <= 1'h0;
    endtask : kick

    initial begin
        repeat (20) @(posedge aclk);
        aresetn <= 1'h1;
        @(negedge aclk);
        `CHK("reset mode", 3'h0, eff_mode)
        `CHK("reset app clk", 1'h1, app_clk_en)
        wr(8'h10, 32'h1, rsp);
        `CHK("unmapped bresp", 2'h2, rsp)
        wr(8'h08, 32'he4, rsp);
        rd(8'h08, dat);
        `CHK("iopull readback", 8'he4, dat[7:0])
        go(32'h1, 3'h1);
        `CHK("sleep app clk", 1'h0, app_clk_en)
        kick(5);
        wait_mode(3'h0);
        wr(8'h00, 32'h2, rsp);
        wait_mode(3'h2);
        `CHK("lprun cap", 1'h1, app_clk_cap_2mhz)
        `CHK("lprun lp reg", 1'h1, low_power_regulator_en)
        go(32'h3, 3'h3);
        kick(5);
        wait_mode(3'h2);
        wr(8'h00, 32'h0, rsp);
        wait_mode(3'h0);
        radio_on <= 1'h1;
        radio_lvl <= 3'h5;
        periph_hsi_req <= 1'h1;
        slow <= 1'h1;
        go(32'h4, 3'h4);
        `CHK("stop0 main reg", 1'h1, main_regulator_en)
        `CHK("stop0 slow osc", 1'h1, low_speed_osc_en)
        `CHK("stop0 radio wait", 1'h1, radio_wait_en)
        `CHK("stop0 hsi", 1'h1, internal_16mhz_oscillator_en)
        kick(5);
        wait_mode(3'h0);
        `CHK("stop exit radio clk", lpm_pkg::CLK_F16, sysclk_sel)
        radio_on <= 1'h0;
        go(32'h15, 3'h5);
        `CHK("stop1 main reg", 1'h0, main_regulator_en)
        `CHK("stop1 sram", 1'h1, memory_bank_two_b_ret)
        kick(5);
        wait_mode(3'h0);
        `CHK("stop exit fast", lpm_pkg::CLK_MHI, sysclk_sel)
        radio_on <= 1'h1;
        radio_lvl <= 3'h0;
        go(32'h5, 3'h0);
        repeat (30) @(negedge aclk);
        `CHK("radio holds run", 3'h0, eff_mode)
        radio_on <= 1'h0;
        wait_mode(3'h5);
        kick(5);
        wait_mode(3'h0);
        slow <= 1'h0;
        // each standby wake source in turn
        for (int i = 0; i < 5; i++) begin
            wr(8'h08, 32'he4, rsp);
            go(32'h66, 3'h6);
            `CHK("stby core", 1'h0, core_supply_domain_on)
            `CHK("stby brownout", 1'h1, brownout_monitor_en)
            `CHK("stby sram", 1'h1, memory_bank_one_ret)
            `CHK("stby rtc", 1'h1, rtc_en)
            `CHK("stby io pull", 8'he4, io_pull)
            kick(i);
            wait_mode(3'h0);
            `CHK("stby wake clk", lpm_pkg::CLK_F16, sysclk_sel)
        end
        go(32'h7, 3'h7);
        `CHK("shut brownout", 1'h0, brownout_monitor_en)
        `CHK("shut sram", 1'h0, memory_bank_two_a_ret)
        kick(1);
        repeat (30) @(negedge aclk);
        `CHK("shut ignores watchdog", 3'h7, eff_mode)
        kick(2);
        wait_mode(3'h0);
        `CHK("shut wake clk", lpm_pkg::CLK_M4, sysclk_sel)
        finish_test();
    end

    // hang guard, far beyond the run length
    initial begin
        repeat (20000) @(posedge aclk);
        num_errors++;
        finish_test();
    end
endmodule : test_low_power_mode_controller
